// File: hdl/cfr_alu_if.sv
// carrier between the core and the flag calculator
`default_nettype none
interface cfr_alu_if;
    cfr_pkg::cfr_op_t kind;
    logic word;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] result;
    logic ext_carry;
    logic ext_ovf;
    logic [7:0] flags;
    logic [7:0] next_flags;

    modport core (output kind, word, a, b, result, ext_carry, ext_ovf,
                  flags, input next_flags);
    modport calc (input kind, word, a, b, result, ext_carry, ext_ovf,
                  flags, output next_flags);
endinterface : cfr_alu_if
`default_nettype wire

// File: hdl/cfr_core.sv
// cpu status word, priority level and working register pointers
// Operation
// - priority level 000 highest, 111 lowest
// - preempted priority level saved in nested store
// - status word saved per interrupt, seven deep
// - carry marks carry out of bit 7/15
// - carry set, clear and invert operations
// - zero set when accumulator result is zero
// - sign copies result bit 7 or 15
// - overflow marks two's-complement range error
// - bcd adjust kind records add or subtract
// - half carry is carry/borrow at bit 3 of byte ops; word ops keep it
// - status bit 1 reserved, always zero
// - memory area select set/cleared by select ops
// - pointers count 32 blocks of 8 registers
// - single op single mode, low/high ops twin
// - single mode rounds odd block down to even
// - twin mode: r0-r7 pointer zero, r8-r15 one
// - group D never reached by direct address
// - pointer zero bits 7:3 hold block number
// - status word clears to zero on reset
// - twin bit 2 set by twin ops, 1:0 zero
`default_nettype none
`include "cfr_map.svh"
module cfr_core (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic op_valid,
    input wire cfr_pkg::cfr_op_t op_kind,
    input wire logic op_word,
    input wire logic [15:0] op_a,
    input wire logic [15:0] op_b,
    input wire logic [15:0] op_result,
    input wire logic op_carry,
    input wire logic op_overflow,
    input wire logic spm_op,
    input wire logic irq_enter,
    input wire logic [2:0] irq_level,
    input wire logic irq_return,
    input wire cfr_pkg::cfr_ptr_op_t ptr_op,
    input wire logic [4:0] ptr_block,
    input wire logic [3:0] wreg_num,
    output logic [7:0] wreg_addr,
    input wire logic [7:0] direct_addr,
    output logic direct_ok,
    output logic [7:0] status_word,
    output logic [2:0] priority_level,
    output logic twin_mode
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // register file address of working register n
    function automatic logic [7:0] cfr_wreg(input logic twin,
                                            input logic [4:0] b0,
                                            input logic [4:0] b1,
                                            input logic [3:0] n);
        logic [4:0] blk;
        if (twin) begin
            blk = n[3] ? b1 : b0;
            return {blk, n[2:0]};
        end
        return {b0[4:1], n};
    endfunction : cfr_wreg

    // ---------------------------------------------------------------
    // flag calculator and nesting store
    // ---------------------------------------------------------------
    cfr_pkg::cfr_core_t state;
    cfr_pkg::cfr_core_t next_state;
    cfr_pkg::cfr_entry_t top_entry;
    cfr_pkg::cfr_entry_t push_entry;
    logic [2:0] nest_depth;
    logic nest_full;

    cfr_alu_if alu ();

    assign alu.kind = op_valid ? op_kind : cfr_pkg::CFR_OP_NONE;
    assign alu.word = op_word;
    assign alu.a = op_a;
    assign alu.b = op_b;
    assign alu.result = op_result;
    assign alu.ext_carry = op_carry;
    assign alu.ext_ovf = op_overflow;
    assign alu.flags = state.flags;

    cfr_flag_unit u_flags (
        .alu(alu)
    );

    assign push_entry = '{flags: state.flags, level: state.cpl};

    cfr_nest_stack u_nest (
        .clock(clock),
        .resetn(resetn),
        .push(irq_enter),
        .pop(irq_return),
        .push_data(push_entry),
        .top_data(top_entry),
        .depth(nest_depth),
        .full(nest_full)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        // execution step updates
        next_state.flags = alu.next_flags;
        if (spm_op) begin
            next_state.flags[`CFR_BIT_MEM] = 1'b0;
        end
        unique case (ptr_op)
            cfr_pkg::CFR_PTR_NONE: begin
            end
            cfr_pkg::CFR_PTR_SINGLE: begin
                next_state.wp0 = ptr_block;
                next_state.twin = 1'b0;
            end
            cfr_pkg::CFR_PTR_LOW: begin
                next_state.wp0 = ptr_block;
                next_state.twin = 1'b1;
            end
            cfr_pkg::CFR_PTR_HIGH: begin
                next_state.wp1 = ptr_block;
                next_state.twin = 1'b1;
            end
        endcase
        // software writes to the system registers
        if (reg_wr) begin
            unique case (reg_addr)
                `CFR_OFS_PRIO: begin
                    next_state.cpl = reg_wdata[2:0];
                end
                `CFR_OFS_STATUS: begin
                    next_state.flags = reg_wdata;
                    next_state.flags[`CFR_BIT_RSV] = 1'b0;
                end
                `CFR_OFS_WP0: begin
                    next_state.wp0 =
                        reg_wdata[`CFR_PTR_BLK_HI:`CFR_PTR_BLK_LO];
                    next_state.twin = reg_wdata[`CFR_PTR_TWIN];
                end
                `CFR_OFS_WP1: begin
                    next_state.wp1 =
                        reg_wdata[`CFR_PTR_BLK_HI:`CFR_PTR_BLK_LO];
                    next_state.twin = reg_wdata[`CFR_PTR_TWIN];
                end
                default: begin
                end
            endcase
        end
        // interrupt entry and return take precedence
        if (irq_enter && !irq_return && !nest_full) begin
            next_state.cpl = irq_level;
        end else if (irq_return && !irq_enter && (nest_depth != 3'h0)) begin
            next_state.flags = top_entry.flags;
            next_state.cpl = top_entry.level;
        end
        // read data and address translation
        unique case (reg_addr)
            `CFR_OFS_PRIO: next_state.rdata = {5'h00, state.cpl};
            `CFR_OFS_STATUS: next_state.rdata = state.flags;
            `CFR_OFS_WP0:
                next_state.rdata = {state.wp0, state.twin, 2'h0};
            `CFR_OFS_WP1:
                next_state.rdata = {state.wp1, state.twin, 2'h0};
            default: next_state.rdata = 8'h00;
        endcase
        next_state.wreg_addr = cfr_wreg(state.twin, state.wp0, state.wp1,
                                        wreg_num);
        next_state.direct_ok = (direct_addr[7:4] != `CFR_GROUP_D);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
            state.flags <= `CFR_RST_STATUS;
            state.cpl <= `CFR_RST_PRIO;
            state.wp0 <= `CFR_RST_BLOCK;
            state.wp1 <= `CFR_RST_BLOCK;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign wreg_addr = state.wreg_addr;
    assign direct_ok = state.direct_ok;
    assign status_word = state.flags;
    assign priority_level = state.cpl;
    assign twin_mode = state.twin;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    logic quiet;
    assign quiet = !reg_wr && !irq_enter && !irq_return && !spm_op;

    sequence s_enter;
        irq_enter && !irq_return && !nest_full;
    endsequence

    sequence s_leave;
        irq_return && !irq_enter && !reg_wr;
    endsequence

    a_reserved_zero: assert property (
        status_word[`CFR_BIT_RSV] == 1'b0)
        else $error("reserved status bit not zero");

    a_carry_set: assert property (
        op_valid && op_kind == cfr_pkg::CFR_OP_SCF && quiet
        |=> status_word[`CFR_BIT_C])
        else $error("carry set op failed");

    a_carry_invert: assert property (
        op_valid && op_kind == cfr_pkg::CFR_OP_CCF && quiet
        |=> status_word[`CFR_BIT_C] != $past(status_word[`CFR_BIT_C]))
        else $error("carry invert op failed");

    a_byte_add_flags: assert property (
        op_valid && op_kind == cfr_pkg::CFR_OP_ADD && !op_word && quiet
        |=> status_word[`CFR_BIT_C] ==
            ((9'($past(op_a[7:0])) + 9'($past(op_b[7:0]))) > 9'h0FF))
        else $error("byte carry wrong");

    a_zero_sign: assert property (
        op_valid && op_kind == cfr_pkg::CFR_OP_LOGIC && quiet
        |=> status_word[`CFR_BIT_Z] ==
                cfr_pkg::cfr_zero($past(op_word), $past(op_result))
            && status_word[`CFR_BIT_S] ==
                cfr_pkg::cfr_msb($past(op_word), $past(op_result)))
        else $error("zero or sign flag wrong");

    a_twin_select: assert property (
        ptr_op == cfr_pkg::CFR_PTR_HIGH && !reg_wr
        ##1 ptr_op == cfr_pkg::CFR_PTR_NONE && !reg_wr
        |=> twin_mode && wreg_num == 4'h8
            |-> ##1 wreg_addr == {$past(ptr_block, 3), 3'h0})
        else $error("high pointer op not mapped");

    a_single_even: assert property (
        !twin_mode |=> wreg_addr[3] == $past(wreg_num[3]))
        else $error("single mode block not even");

    a_nest_restore: assert property (
        s_enter ##1 s_leave
        |=> priority_level == $past(priority_level, 2)
            && status_word == $past(status_word, 2))
        else $error("nested restore wrong");

    a_group_d_blocked: assert property (
        direct_addr[7:4] == `CFR_GROUP_D |=> !direct_ok)
        else $error("group D reachable directly");

    a_carry_clear: assert property (
        op_valid && op_kind == cfr_pkg::CFR_OP_RCF && quiet
        |=> !status_word[`CFR_BIT_C])
        else $error("carry clear failed");

    a_mem_select: assert property (
        spm_op && !reg_wr && !irq_return
        |=> !status_word[`CFR_BIT_MEM])
        else $error("code space select failed");

    a_ptr_single: assert property (
        ptr_op == cfr_pkg::CFR_PTR_SINGLE && !reg_wr
        |=> !twin_mode)
        else $error("single op kept twin mode");

    a_level_enter: assert property (
        s_enter |=> priority_level == $past(irq_level))
        else $error("entry level not taken");

    a_full_hold: assert property (
        irq_enter && !irq_return && nest_full && !reg_wr
        |=> $stable(priority_level))
        else $error("eighth entry taken");

    a_level_read: assert property (
        reg_addr == `CFR_OFS_PRIO
        |=> reg_rdata == {5'h00, $past(priority_level)})
        else $error("level read wrong");

endmodule : cfr_core
`default_nettype wire

// File: hdl/cfr_flag_unit.sv
// combinational next-status-word calculator
`default_nettype none
`include "cfr_map.svh"
module cfr_flag_unit (
    cfr_alu_if.calc alu
);
    logic [7:0] nf;
    logic [15:0] a;
    logic [15:0] b;
    logic [16:0] sum;
    logic cin;
    logic sub;
    logic sa;
    logic sb;
    logic sr;

    always_comb begin
        nf = alu.flags;
        a = alu.word ? alu.a : {8'h00, alu.a[7:0]};
        b = alu.word ? alu.b : {8'h00, alu.b[7:0]};
        sub = (alu.kind == cfr_pkg::CFR_OP_SUB) ||
              (alu.kind == cfr_pkg::CFR_OP_SBC) ||
              (alu.kind == cfr_pkg::CFR_OP_CMP);
        cin = ((alu.kind == cfr_pkg::CFR_OP_ADC) ||
               (alu.kind == cfr_pkg::CFR_OP_SBC)) & alu.flags[`CFR_BIT_C];
        sum = sub ? ({1'b0, a} - {1'b0, b} - {16'h0000, cin})
                  : ({1'b0, a} + {1'b0, b} + {16'h0000, cin});
        sa = cfr_pkg::cfr_msb(alu.word, a);
        sb = cfr_pkg::cfr_msb(alu.word, b);
        sr = cfr_pkg::cfr_msb(alu.word, sum[15:0]);
        unique case (alu.kind)
            cfr_pkg::CFR_OP_NONE: begin
            end
            cfr_pkg::CFR_OP_ADD, cfr_pkg::CFR_OP_ADC, cfr_pkg::CFR_OP_SUB,
            cfr_pkg::CFR_OP_SBC, cfr_pkg::CFR_OP_CMP: begin
                nf[`CFR_BIT_C] = alu.word ? sum[16] : sum[8];
                nf[`CFR_BIT_Z] =
                    cfr_pkg::cfr_zero(alu.word, sum[15:0]);
                nf[`CFR_BIT_S] = sr;
                nf[`CFR_BIT_V] = sub ? ((sa != sb) && (sr != sa))
                                     : ((sa == sb) && (sr != sa));
                nf[`CFR_BIT_BCD] = sub;
                if (!alu.word) begin
                    nf[`CFR_BIT_H] = a[4] ^ b[4] ^ sum[4];
                end
            end
            cfr_pkg::CFR_OP_LOGIC, cfr_pkg::CFR_OP_INCDEC,
            cfr_pkg::CFR_OP_TEST: begin
                nf[`CFR_BIT_Z] =
                    cfr_pkg::cfr_zero(alu.word, alu.result);
                nf[`CFR_BIT_S] =
                    cfr_pkg::cfr_msb(alu.word, alu.result);
                nf[`CFR_BIT_V] = alu.ext_ovf;
            end
            cfr_pkg::CFR_OP_SHIFT, cfr_pkg::CFR_OP_DECADJ,
            cfr_pkg::CFR_OP_MULDIV: begin
                nf[`CFR_BIT_C] = alu.ext_carry;
                nf[`CFR_BIT_Z] =
                    cfr_pkg::cfr_zero(alu.word, alu.result);
                nf[`CFR_BIT_S] =
                    cfr_pkg::cfr_msb(alu.word, alu.result);
                nf[`CFR_BIT_V] = alu.ext_ovf;
            end
            cfr_pkg::CFR_OP_SCF: begin
                nf[`CFR_BIT_C] = 1'b1;
            end
            cfr_pkg::CFR_OP_RCF: begin
                nf[`CFR_BIT_C] = 1'b0;
            end
            cfr_pkg::CFR_OP_CCF: begin
                nf[`CFR_BIT_C] = ~alu.flags[`CFR_BIT_C];
            end
            cfr_pkg::CFR_OP_SDM: begin
                nf[`CFR_BIT_MEM] = 1'b1;
            end
        endcase
        nf[`CFR_BIT_RSV] = 1'b0;
        alu.next_flags = nf;
    end

endmodule : cfr_flag_unit
`default_nettype wire

// File: hdl/cfr_map.svh
// constants: register offsets, field positions, reset values, depths
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH

// ---------------------------------------------------------------
// system register offsets
// ---------------------------------------------------------------
`define CFR_OFS_PRIO 8'hE6
`define CFR_OFS_STATUS 8'hE7
`define CFR_OFS_WP0 8'hE8
`define CFR_OFS_WP1 8'hE9

// ---------------------------------------------------------------
// status word fields
// ---------------------------------------------------------------
`define CFR_BIT_C 7
`define CFR_BIT_Z 6
`define CFR_BIT_S 5
`define CFR_BIT_V 4
`define CFR_BIT_BCD 3
`define CFR_BIT_H 2
`define CFR_BIT_RSV 1
`define CFR_BIT_MEM 0

// ---------------------------------------------------------------
// pointer fields, group limits, reset values, depth
// ---------------------------------------------------------------
`define CFR_PTR_BLK_HI 7
`define CFR_PTR_BLK_LO 3
`define CFR_PTR_TWIN 2
`define CFR_GROUP_D 4'hD
`define CFR_RST_STATUS 8'h00
`define CFR_RST_PRIO 3'h7
`define CFR_RST_BLOCK 5'h00
`define CFR_NEST_DEPTH 7

`endif

// File: hdl/cfr_nest_stack.sv
// save area for status word and priority level across nested interrupts
`default_nettype none
`include "cfr_map.svh"
module cfr_nest_stack (
    input wire logic clock,
    input wire logic resetn,
    input wire logic push,
    input wire logic pop,
    input wire cfr_pkg::cfr_entry_t push_data,
    output cfr_pkg::cfr_entry_t top_data,
    output logic [2:0] depth,
    output logic full
);
    typedef struct packed {
        cfr_pkg::cfr_entry_t [`CFR_NEST_DEPTH-1:0] slot;
        logic [2:0] cnt;
    } cfr_stack_t;

    cfr_stack_t state;
    cfr_stack_t next_state;

    always_comb begin
        next_state = state;
        if (push && !pop && (state.cnt != 3'(`CFR_NEST_DEPTH))) begin
            next_state.slot[state.cnt] = push_data;
            next_state.cnt = state.cnt + 3'h1;
        end else if (pop && !push && (state.cnt != 3'h0)) begin
            next_state.cnt = state.cnt - 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign top_data = (state.cnt == 3'h0) ? '0 : state.slot[state.cnt - 3'h1];
    assign depth = state.cnt;
    assign full = (state.cnt == 3'(`CFR_NEST_DEPTH));

endmodule : cfr_nest_stack
`default_nettype wire

// File: hdl/cfr_pkg.sv
// types and shared decode functions of the cpu flag and pointer block
`default_nettype none
package cfr_pkg;

    typedef enum logic [3:0] {
        CFR_OP_NONE, CFR_OP_ADD, CFR_OP_ADC, CFR_OP_SUB, CFR_OP_SBC,
        CFR_OP_CMP, CFR_OP_LOGIC, CFR_OP_INCDEC, CFR_OP_TEST,
        CFR_OP_SHIFT, CFR_OP_DECADJ, CFR_OP_MULDIV, CFR_OP_SCF,
        CFR_OP_RCF, CFR_OP_CCF, CFR_OP_SDM
    } cfr_op_t;

    typedef enum logic [1:0] {
        CFR_PTR_NONE, CFR_PTR_SINGLE, CFR_PTR_LOW, CFR_PTR_HIGH
    } cfr_ptr_op_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [2:0] level;
    } cfr_entry_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [2:0] cpl;
        logic [4:0] wp0;
        logic [4:0] wp1;
        logic twin;
        logic [7:0] rdata;
        logic [7:0] wreg_addr;
        logic direct_ok;
    } cfr_core_t;

    // sign bit at operand width
    function automatic logic cfr_msb(input logic word, input logic [15:0] v);
        return word ? v[15] : v[7];
    endfunction : cfr_msb

    // zero test at operand width
    function automatic logic cfr_zero(input logic word,
                                      input logic [15:0] v);
        return word ? (v == 16'h0000) : (v[7:0] == 8'h00);
    endfunction : cfr_zero

endpackage : cfr_pkg
`default_nettype wire

// File: test/cfr_exec_model.sv
// model of the execution and interrupt sequencer feeding the core
`default_nettype none
module cfr_exec_model (
    input wire logic clock,
    output var logic op_valid,
    output var cfr_pkg::cfr_op_t op_kind,
    output var logic op_word,
    output var logic [15:0] op_a,
    output var logic [15:0] op_b,
    output var logic [15:0] op_result,
    output var logic op_carry,
    output var logic op_overflow,
    output var logic spm_op,
    output var logic irq_enter,
    output var logic [2:0] irq_level,
    output var logic irq_return,
    output var cfr_pkg::cfr_ptr_op_t ptr_op,
    output var logic [4:0] ptr_block
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {op_valid, op_word, op_carry, op_overflow} = 4'h0;
        {op_a, op_b, op_result} = 48'h0;
        {spm_op, irq_enter, irq_return, irq_level} = 6'h0;
        op_kind = cfr_pkg::CFR_OP_NONE;
        ptr_op = cfr_pkg::CFR_PTR_NONE;
        ptr_block = 5'h00;
    end

    // one operation for one cycle, operands scrambled once released
    task automatic run_op(input cfr_pkg::cfr_op_t k, input logic w,
        input logic [15:0] a, input logic [15:0] b, input logic [15:0] r,
        input logic c, input logic v);
        @(negedge clock);
        {op_valid, op_kind, op_word, op_a, op_b} = {1'h1, k, w, a, b};
        {op_result, op_carry, op_overflow} = {r, c, v};
        @(negedge clock);
        {op_valid, op_a, op_b, op_result} = {1'h0, ~a, ~b, ~r};
        op_kind = cfr_pkg::CFR_OP_NONE;
    endtask : run_op

    // data space select at program start
    task automatic start_program();
        run_op(cfr_pkg::CFR_OP_SDM, 1'h0, 16'h0, 16'h0, 16'h0, 1'h0,
               1'h0);
    endtask : start_program

    task automatic code_space();
        @(negedge clock);
        spm_op = 1'h1;
        @(negedge clock);
        spm_op = 1'h0;
    endtask : code_space

    task automatic irq(input logic en, input logic ret,
        input logic [2:0] lvl);
        @(negedge clock);
        {irq_enter, irq_return, irq_level} = {en, ret & ~en, lvl};
        if (en && ret) begin
            @(negedge clock);
            {irq_enter, irq_return} = 2'h1;
        end
        @(negedge clock);
        {irq_enter, irq_return, irq_level} = {2'h0, ~lvl};
    endtask : irq

    task automatic set_ptr(input cfr_pkg::cfr_ptr_op_t p,
        input logic [4:0] blk);
        @(negedge clock);
        {ptr_op, ptr_block} = {p, blk};
        @(negedge clock);
        {ptr_op, ptr_block} = {cfr_pkg::CFR_PTR_NONE, ~blk};
    endtask : set_ptr
endmodule : cfr_exec_model
`default_nettype wire

// File: test/cpu_flags_and_reg_pointers_tb.sv
// self-checking bench of the cpu flag and pointer core
`default_nettype none
module cpu_flags_and_reg_pointers_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] reg_addr = 8'hE7;
    logic reg_wr = 1'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [3:0] wreg_num = 4'h0;
    logic [7:0] direct_addr = 8'h00;
    logic op_valid, op_word, op_carry, op_overflow, spm_op;
    logic irq_enter, irq_return, direct_ok, twin_mode;
    cfr_pkg::cfr_op_t op_kind;
    cfr_pkg::cfr_ptr_op_t ptr_op;
    logic [15:0] op_a, op_b, op_result, a, b;
    logic [2:0] irq_level, priority_level, epl;
    logic [4:0] ptr_block;
    logic [7:0] reg_rdata, wreg_addr, status_word, est, d;
    logic [7:0] sv_st [7];
    logic [2:0] sv_pl [7];
    logic [1:0] k;
    logic w, c, v;
    int failures = 0;
    int check_count = 0;

    always #50 clock = ~clock;

    cfr_exec_model pex_u (.clock, .op_valid, .op_kind, .op_word, .op_a,
        .op_b, .op_result, .op_carry, .op_overflow, .spm_op, .irq_enter,
        .irq_level, .irq_return, .ptr_op, .ptr_block);

    cfr_core dut_u (.clock, .resetn, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata, .op_valid, .op_kind, .op_word, .op_a, .op_b,
        .op_result, .op_carry, .op_overflow, .spm_op, .irq_enter,
        .irq_level, .irq_return, .ptr_op, .ptr_block, .wreg_num,
        .wreg_addr, .direct_addr, .direct_ok, .status_word,
        .priority_level, .twin_mode);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        @(negedge clock);
        {reg_addr, reg_wr, reg_wdata} = {ad, 1'h1, dt};
        @(negedge clock);
        {reg_wr, reg_wdata} = {1'h0, ~dt};
    endtask : wr

    task automatic rd_chk(input logic [7:0] ad, input logic [7:0] e);
        @(negedge clock);
        reg_addr = ad;
        @(negedge clock);
        check(reg_rdata, e);
    endtask : rd_chk

    task automatic wchk(input logic [3:0] n, input logic [7:0] e);
        @(negedge clock);
        wreg_num = n;
        repeat (2) @(negedge clock);
        check(wreg_addr, e);
    endtask : wchk

    task automatic simple(input cfr_pkg::cfr_op_t kk);
        pex_u.run_op(kk, 1'h0, 16'h0, 16'h0, 16'h0, 1'h0, 1'h0);
    endtask : simple

    // expected status after add, subtract or compare
    function automatic logic [7:0] arith_flags(input logic [7:0] st,
        input logic sb, input logic ww, input logic [15:0] x0,
        input logic [15:0] y0);
        logic [16:0] r;
        logic [15:0] x;
        logic [15:0] y;
        logic xs, ys, rs, cy, z, h;
        x = ww ? x0 : {8'h00, x0[7:0]};
        y = ww ? y0 : {8'h00, y0[7:0]};
        r = sb ? {1'h0, x} - {1'h0, y} : {1'h0, x} + {1'h0, y};
        {xs, ys, rs} = ww ? {x[15], y[15], r[15]} : {x[7], y[7], r[7]};
        cy = ww ? r[16] : r[8];
        z = ww ? (r[15:0] == 16'h0000) : (r[7:0] == 8'h00);
        h = sb ? (x[3:0] < y[3:0]) : ({1'h0, x[3:0]} + y[3:0] > 5'h0F);
        if (ww) h = st[2];
        return {cy, z, rs, (sb ? xs != ys : xs == ys) && rs != xs, sb, h,
                1'h0, st[0]};
    endfunction : arith_flags

    task automatic arith(input logic [1:0] kk, input logic ww,
        input logic [15:0] x, input logic [15:0] y);
        pex_u.run_op(kk == 2'h0 ? cfr_pkg::CFR_OP_ADD : kk == 2'h1 ?
            cfr_pkg::CFR_OP_SUB : cfr_pkg::CFR_OP_CMP, ww, x, y, 16'h0,
            1'h0, 1'h0);
        est = arith_flags(est, kk != 2'h0, ww, x, y);
        check(status_word, est);
    endtask : arith

    initial begin
        repeat (30000) @(posedge clock);
        failures++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(95527));
        repeat (16) @(negedge clock);
        check(status_word, 8'h00);
        check(priority_level, 3'h7);
        resetn = 1'h1;
        pex_u.start_program();
        est = 8'h01;
        check(status_word, est);
        pex_u.code_space();
        est = 8'h00;
        check(status_word, est);
        simple(cfr_pkg::CFR_OP_SCF);
        check(status_word, 8'h80);
        simple(cfr_pkg::CFR_OP_CCF);
        check(status_word, 8'h00);
        simple(cfr_pkg::CFR_OP_CCF);
        check(status_word, 8'h80);
        simple(cfr_pkg::CFR_OP_RCF);
        check(status_word, 8'h00);
        $display("test reset_space_carry done");
        est = 8'h00;
        arith(2'h0, 1'h0, 16'h0080, 16'h0080);
        arith(2'h1, 1'h1, 16'h8000, 16'h0001);
        repeat (40) begin
            {a, b, w, k} = {16'($urandom), 16'($urandom), 1'($urandom),
                            2'($urandom % 3)};
            if ($urandom % 4 == 0) b = a;
            arith(k, w, a, b);
        end
        repeat (12) begin
            {a, w, c, v, k} = {16'($urandom), 1'($urandom), 1'($urandom),
                               1'($urandom), 2'($urandom)};
            if (k == 2'h0) a = 16'h0000;
            pex_u.run_op(k[1] ? cfr_pkg::CFR_OP_SHIFT : cfr_pkg::CFR_OP_LOGIC,
                         w, ~a, a, a, c, v);
            est = {k[1] ? c : est[7], w ? a == 16'h0 : a[7:0] == 8'h0,
                   w ? a[15] : a[7], v, est[3:2], 1'h0, est[0]};
            check(status_word, est);
        end
        $display("test flags done");
        epl = 3'h7;
        for (int i = 0; i < 7; i++) begin
            d = 8'($urandom);
            wr(8'hE7, d);
            est = d & 8'hFD;
            check(status_word, est);
            {sv_st[i], sv_pl[i], epl} = {est, epl, 3'($urandom)};
            pex_u.irq(1'h1, 1'h0, epl);
            check(priority_level, epl);
        end
        pex_u.irq(1'h1, 1'h0, ~epl);
        check(priority_level, epl);
        for (int i = 6; i >= 0; i--) begin
            pex_u.irq(1'h0, 1'h1, 3'h0);
            check(status_word, sv_st[i]);
            check(priority_level, sv_pl[i]);
        end
        pex_u.irq(1'h0, 1'h1, 3'h0);
        check(priority_level, 3'h7);
        wr(8'hE6, 8'hF3);
        rd_chk(8'hE6, 8'h03);
        check(priority_level, 3'h3);
        pex_u.irq(1'h1, 1'h1, 3'h1);
        check(priority_level, 3'h3);
        rd_chk(8'hE7, sv_st[0]);
        $display("test nesting done");
        pex_u.set_ptr(cfr_pkg::CFR_PTR_SINGLE, 5'h03);
        check(twin_mode, 1'h0);
        rd_chk(8'hE8, 8'h18);
        wchk(4'h0, 8'h10);
        wchk(4'hF, 8'h1F);
        pex_u.set_ptr(cfr_pkg::CFR_PTR_LOW, 5'h04);
        wreg_num = 4'h8;
        pex_u.set_ptr(cfr_pkg::CFR_PTR_HIGH, 5'h09);
        check(twin_mode, 1'h1);
        rd_chk(8'hE8, 8'h24);
        rd_chk(8'hE9, 8'h4C);
        check(wreg_addr, 8'h48);
        repeat (8) begin
            k = 2'($urandom);
            wchk({k[0], 3'h5}, {k[0] ? 5'h09 : 5'h04, 3'h5});
        end
        $display("test pointers done");
        repeat (20) begin
            d = 8'($urandom);
            if ($urandom % 2) d[7:4] = 4'hD;
            @(negedge clock);
            direct_addr = d;
            @(negedge clock);
            check(direct_ok, d[7:4] != 4'hD);
        end
        $display("test direct done");
        tally_and_finish();
    end
endmodule : cpu_flags_and_reg_pointers_tb
`default_nettype wire
